/* mcsc_defs.vh */
// Purpose: Constants for the main clock source control block
// Assumes: Single 100 MHz system clock, all controls synchronous
// Notes:   Definitions only
`ifndef MCSC_DEFS_VH
`define MCSC_DEFS_VH
// ----------------------------------------
// Divider ratio codes
// ----------------------------------------
`define MCSC_DIV_W        3
`define MCSC_DIV_1        3'h0
`define MCSC_DIV_2        3'h1
`define MCSC_DIV_4        3'h2
`define MCSC_DIV_8        3'h3
`define MCSC_DIV_16       3'h4
`define MCSC_DIV_RESET    3'h1
// ----------------------------------------
// Pin modes
// ----------------------------------------
`define MCSC_PIN_PORT     2'h0
`define MCSC_PIN_XTAL     2'h1
`define MCSC_PIN_EXT      2'h2
// ----------------------------------------
// Clock sources
// ----------------------------------------
`define MCSC_SRC_INT      2'h0
`define MCSC_SRC_HS       2'h1
`define MCSC_SRC_SUB      2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define MCSC_SETTLE_NS    2000
`define MCSC_CLK_NS       10
`define MCSC_PRE_W        4
`define MCSC_PRE_MAX      4'hF
`endif

/* mcsc_main_clock_ctrl.v */
// Purpose: Main clock source selection, gating and CPU clock division
// Assumes: Clocks modelled as one-cycle enables of clk_sys
// Notes:   Main and CPU source and ratio changes take effect only on a period boundary
//
// Summary of operation
// - After reset both high-speed pins stay general-purpose port mode.
// - External select 0 with pin select 1 gives resonator oscillation mode.
// - Both selects 1 give external clock input on second pin only.
// - Clearing main oscillator stop starts oscillator or enables external input.
// - Setting main oscillator stop stops oscillator or disables external input.
// - Main and peripheral selects both 1 feed high-speed clock to both.
// - High-speed main clock forbids any other peripheral clock source.
// - Main select 0 gives internal clock to both; 1/0 splits them.
// - CPU source 0 divides main clock by 1,2,4,8,16 per ratio field.
// - Two status bits report internal, high-speed or subsystem CPU clock.
// - STOP mode halts crystal oscillation or external clock input.
// - Clearing internal oscillator stop restarts internal oscillator.
// - Stable flag rises once restarted internal oscillator accuracy settles.
// - Reset starts internal oscillator and selects it for the CPU.
// - Setting internal oscillator stop halts the internal clock.
// - CPU source 1 feeds the subsystem clock to the CPU.
`timescale 1ns/1ps
`default_nettype none
`include "mcsc_defs.vh"
module mcsc_main_clock_ctrl #(
  parameter SETTLE_CYC = (`MCSC_SETTLE_NS + `MCSC_CLK_NS - 1) / `MCSC_CLK_NS
) (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   nrst,
  // Oscillator pin control
  input  wire                   ext_input_select,
  input  wire                   hs_pin_mode_select,
  input  wire                   main_osc_stop,
  input  wire                   internal_hs_osc_stop,
  input  wire                   stop_mode,
  // Clock mode control
  input  wire                   main_source_select,
  input  wire                   peripheral_source_select,
  input  wire                   cpu_source_select,
  input  wire [`MCSC_DIV_W-1:0] cpu_divider,
  // Source clock enables
  input  wire                   hs_clk_en,
  input  wire                   sub_clk_en,
  // Pin mode outputs
  output reg                    pin1_osc_mode,
  output reg                    pin2_osc_mode,
  output reg                    pin2_ext_input,
  output reg                    xtal_osc_enable,
  output reg                    ext_input_enable,
  output reg                    internal_hs_run,
  output reg                    internal_hs_stable_flag,
  // Clock enables and status
  output reg                    main_clk_en,
  output reg                    periph_clk_en,
  output reg                    cpu_clk_en,
  output reg                    cpu_on_subsystem_status,
  output reg                    main_on_hs_status
);
  // ----------------------------------------
  // Pin mode and oscillator control
  // ----------------------------------------
  reg [1:0] pin_mode;
  always @* begin
    if (!hs_pin_mode_select) begin
      pin_mode = `MCSC_PIN_PORT;
    end else if (ext_input_select) begin
      pin_mode = `MCSC_PIN_EXT;
    end else begin
      pin_mode = `MCSC_PIN_XTAL;
    end
  end
  wire hs_run_nxt = !main_osc_stop && !stop_mode;
  wire int_run_nxt = !internal_hs_osc_stop && !stop_mode;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin1_osc_mode    <= 1'b0;
      pin2_osc_mode    <= 1'b0;
      pin2_ext_input   <= 1'b0;
      xtal_osc_enable  <= 1'b0;
      ext_input_enable <= 1'b0;
      internal_hs_run  <= 1'b1;
    end else begin
      pin1_osc_mode    <= (pin_mode == `MCSC_PIN_XTAL);
      pin2_osc_mode    <= (pin_mode == `MCSC_PIN_XTAL);
      pin2_ext_input   <= (pin_mode == `MCSC_PIN_EXT);
      xtal_osc_enable  <= (pin_mode == `MCSC_PIN_XTAL) && hs_run_nxt;
      ext_input_enable <= (pin_mode == `MCSC_PIN_EXT) && hs_run_nxt;
      internal_hs_run  <= int_run_nxt;
    end
  end
  // ----------------------------------------
  // Internal oscillator accuracy settle
  // ----------------------------------------
  // Flag drops one cycle after internal_hs_run falls, so a stale stable state lasts at most one cycle
  reg [15:0] settle_r;
  // Counter is 16 bits wide, so settle counts above 65536 never complete
  localparam [31:0] SETTLE_LAST = SETTLE_CYC - 1;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      settle_r                <= 16'h0000;
      internal_hs_stable_flag <= 1'b0;
    end else if (!internal_hs_run) begin
      settle_r                <= 16'h0000;
      internal_hs_stable_flag <= 1'b0;
    end else if ({16'h0000, settle_r} >= SETTLE_LAST) begin
      internal_hs_stable_flag <= 1'b1;
    end else begin
      settle_r <= settle_r + 16'h0001;
    end
  end
  // ----------------------------------------
  // Main and peripheral source selection
  // ----------------------------------------
  // One helper picks between the two main sources; the main and prescaler paths
  // share one pulse train, while the peripheral path passes it its own select
  function pick_src;
    input use_hs;
    input hs_pulse;
    input int_pulse;
    begin
      if (use_hs) begin
        pick_src = hs_pulse;
      end else begin
        pick_src = int_pulse;
      end
    end
  endfunction
  // Main source follows the selects only at a CPU period boundary, so the
  // prescaler never mixes pulses of two sources inside one CPU period
  reg  main_hs_act_r;
  wire hs_avail  = (xtal_osc_enable | ext_input_enable) & hs_clk_en;
  wire int_tick  = internal_hs_run;
  wire main_hs   = main_source_select & peripheral_source_select;
  // Peripherals keep the high-speed clock while the main clock still uses it
  wire periph_hs = main_source_select | main_hs_act_r;
  wire main_tick = pick_src(main_hs_act_r, hs_avail, int_tick);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      main_clk_en   <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      main_clk_en   <= main_tick;
      periph_clk_en <= pick_src(periph_hs, hs_avail, int_tick);
    end
  end
  // ----------------------------------------
  // CPU divider with glitch-free switching
  // ----------------------------------------
  // New source and ratio are latched only at a period boundary, so no
  // shortened enable period can reach the CPU except on a switch to or from the subsystem clock or away from ratio 1
  // Limitation: if the source in use stops, no boundary comes and the
  // selection stays frozen until that source runs again
  reg [`MCSC_DIV_W-1:0]  div_act_r;
  reg [1:0]              src_act_r;
  reg [1:0]              src_req;
  reg                    boundary;
  wire [`MCSC_PRE_W-1:0] tick;
  mcsc_tick_div #(.W(`MCSC_PRE_W)) u_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .run     (main_tick),
    .tick    (tick)
  );
  function div_pulse;
    input [`MCSC_DIV_W-1:0] code;
    input                   base;
    input [`MCSC_PRE_W-1:0] t;
    begin
      case (code)
        `MCSC_DIV_1:  div_pulse = base;
        `MCSC_DIV_2:  div_pulse = t[0];
        `MCSC_DIV_4:  div_pulse = t[1];
        `MCSC_DIV_8:  div_pulse = t[2];
        `MCSC_DIV_16: div_pulse = t[3];
        default:      div_pulse = t[0];
      endcase
    end
  endfunction
  wire main_cpu_pulse = div_pulse(div_act_r, main_tick, tick);
  wire cpu_pulse = (src_act_r == `MCSC_SRC_SUB) ? sub_clk_en : main_cpu_pulse;
  always @* begin
    if (cpu_source_select) begin
      src_req = `MCSC_SRC_SUB;
    end else if (main_hs) begin
      src_req = `MCSC_SRC_HS;
    end else begin
      src_req = `MCSC_SRC_INT;
    end
  end
  always @* begin
    if (src_act_r == `MCSC_SRC_SUB) begin
      boundary = sub_clk_en;
    end else if (div_act_r == `MCSC_DIV_1) begin
      boundary = main_tick;
    end else begin
      boundary = (tick == `MCSC_PRE_MAX);
    end
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_act_r               <= `MCSC_DIV_RESET;
      src_act_r               <= `MCSC_SRC_INT;
      main_hs_act_r           <= 1'b0;
      cpu_clk_en              <= 1'b0;
      cpu_on_subsystem_status <= 1'b0;
      main_on_hs_status       <= 1'b0;
    end else begin
      cpu_clk_en <= cpu_pulse;
      if (boundary) begin
        div_act_r     <= (cpu_divider > `MCSC_DIV_16) ? div_act_r : cpu_divider;
        src_act_r     <= src_req;
        main_hs_act_r <= main_hs;
      end
      cpu_on_subsystem_status <= (src_act_r == `MCSC_SRC_SUB);
      main_on_hs_status       <= (src_act_r == `MCSC_SRC_HS);
    end
  end
endmodule // mcsc_main_clock_ctrl
`default_nettype wire

/* mcsc_main_clock_ctrl_properties.sv */
// Purpose: Timing properties of the main clock source control ports
// Assumes: One clock domain, async active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module mcsc_main_clock_ctrl_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Observed controls
  input wire logic ext_input_select,
  input wire logic hs_pin_mode_select,
  input wire logic main_osc_stop,
  input wire logic internal_hs_osc_stop,
  input wire logic stop_mode,
  input wire logic sub_clk_en,
  // Observed outputs
  input wire logic pin1_osc_mode,
  input wire logic pin2_osc_mode,
  input wire logic pin2_ext_input,
  input wire logic xtal_osc_enable,
  input wire logic ext_input_enable,
  input wire logic internal_hs_run,
  input wire logic internal_hs_stable_flag,
  input wire logic main_clk_en,
  input wire logic periph_clk_en,
  input wire logic cpu_clk_en,
  input wire logic cpu_on_subsystem_status,
  input wire logic main_on_hs_status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_port; !hs_pin_mode_select |=> !pin1_osc_mode && !pin2_osc_mode && !pin2_ext_input;
  endproperty
  a_port: assert property (p_port) else $error("pins left port mode");
  property p_xtal; hs_pin_mode_select && !ext_input_select |=>
    pin1_osc_mode && pin2_osc_mode && !pin2_ext_input; endproperty
  a_xtal: assert property (p_xtal) else $error("resonator mode wrong");
  property p_ext; hs_pin_mode_select && ext_input_select |=> !pin1_osc_mode && pin2_ext_input;
  endproperty
  a_ext: assert property (p_ext) else $error("external input mode wrong");
  property p_run; hs_pin_mode_select && !main_osc_stop && !stop_mode |=>
    xtal_osc_enable == !ext_input_select && ext_input_enable == ext_input_select; endproperty
  a_run: assert property (p_run) else $error("source not started");
  property p_halt; main_osc_stop || stop_mode |=> !xtal_osc_enable && !ext_input_enable;
  endproperty
  a_halt: assert property (p_halt) else $error("source not halted");
  property p_int_stop; internal_hs_osc_stop |=> !internal_hs_run; endproperty
  a_int_stop: assert property (p_int_stop) else $error("internal osc still runs");
  property p_int_run; !internal_hs_osc_stop && !stop_mode |=> internal_hs_run; endproperty
  a_int_run: assert property (p_int_run) else $error("internal osc not running");
  property p_settle; $rose(internal_hs_stable_flag) |-> internal_hs_run && $past(internal_hs_run, 3);
  endproperty
  a_settle: assert property (p_settle) else $error("stable flag too early");
  property p_hs_pair; main_on_hs_status && !cpu_on_subsystem_status |-> periph_clk_en == main_clk_en;
  endproperty
  a_hs_pair: assert property (p_hs_pair) else $error("peripheral clock differs");
  property p_sub_cpu; cpu_on_subsystem_status && cpu_clk_en |-> $past(sub_clk_en); endproperty
  a_sub_cpu: assert property (p_sub_cpu) else $error("cpu pulse without sub pulse");
endmodule // mcsc_main_clock_ctrl_properties
bind mcsc_main_clock_ctrl mcsc_main_clock_ctrl_properties u_props (.*);
`default_nettype wire

/* mcsc_osc_model.sv */
// Purpose: Resonator or external clock on the high-speed pins
// Assumes: One pulse every PER cycles while enabled
// Notes:   No pulse at all while stopped, as the real source
`timescale 1ns/1ps
`default_nettype none
module mcsc_osc_model #(parameter int PER = 4) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Source control
  input  wire logic xtal_osc_enable,
  input  wire logic ext_input_enable,
  // Source pulses
  output var  logic hs_clk_en
);
  localparam logic [3:0] LAST = 4'(PER - 1);
  logic [3:0] cnt_r;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      hs_clk_en <= 1'b0;
    end else if (!(xtal_osc_enable || ext_input_enable)) begin
      cnt_r <= 4'h0;
      hs_clk_en <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == LAST) ? 4'h0 : cnt_r + 4'h1;
      hs_clk_en <= (cnt_r == LAST);
    end
  end
endmodule // mcsc_osc_model
`default_nettype wire

/* mcsc_tick_div.v */
// Purpose: Run-gated prescaler producing one-cycle enable ticks
// Assumes: Runs on clk_sys
// Notes:   Bit k of tick pulses once every 2^(k+1) run pulses
`timescale 1ns/1ps
`default_nettype none
module mcsc_tick_div #(
  parameter W = 4
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         nrst,
  // Enable
  input  wire         run,
  // Ticks
  output wire [W-1:0] tick
);
  reg [W-1:0] cnt_r;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= {W{1'b0}};
    end else if (run) begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
  genvar k;
  generate
    for (k = 0; k < W; k = k + 1) begin : g_tick
      assign tick[k] = run & (&cnt_r[k:0]);
    end
  endgenerate
endmodule // mcsc_tick_div
`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench of the main clock source control
// Assumes: Inputs driven at the falling edge
// Notes:   Short settle count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0, nrst = 1'b0, ext_input_select = 1'b0, hs_pin_mode_select = 1'b0;
  logic main_osc_stop = 1'b1, internal_hs_osc_stop = 1'b0, stop_mode = 1'b0;
  logic main_source_select = 1'b0, peripheral_source_select = 1'b0, cpu_source_select = 1'b0;
  logic sub_clk_en = 1'b0;
  logic [2:0] cpu_divider = 3'h1, sc = 3'h0;
  logic [7:0] m, p, c;
  logic [7:0] rows [8] = '{8'h20, 8'h78, 8'h5A, 8'h78, 8'hE4, 8'hC5, 8'hE4, 8'h20};
  int bad_count = 0, n_tests = 0, n;
  wire hs_clk_en, pin1_osc_mode, pin2_osc_mode, pin2_ext_input, xtal_osc_enable;
  wire ext_input_enable, internal_hs_run, internal_hs_stable_flag, main_clk_en;
  wire periph_clk_en, cpu_clk_en, cpu_on_subsystem_status, main_on_hs_status;
  wire [4:0] pins = {pin1_osc_mode, pin2_osc_mode, pin2_ext_input, xtal_osc_enable,
                     ext_input_enable};
  wire [7:0] stat = {6'h0, cpu_on_subsystem_status, main_on_hs_status};
  mcsc_main_clock_ctrl #(.SETTLE_CYC(4)) dut (.*);
  mcsc_osc_model osc (.clk_sys, .nrst, .xtal_osc_enable, .ext_input_enable, .hs_clk_en);
  always #5 clk_sys = ~clk_sys;
  // Subsystem source: one pulse every 8 cycles
  always @(negedge clk_sys) begin
    sc <= sc + 3'h1;
    sub_clk_en <= (sc == 3'h7);
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Waits out one full 16-tick boundary of the slowest main source, then
  // counts enables over 64 cycles
  task automatic cnt;
    cyc(80);
    m = 8'h0;
    p = 8'h0;
    c = 8'h0;
    repeat (64) begin
      cyc(1);
      m += main_clk_en;
      p += periph_clk_en;
      c += cpu_clk_en;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(6);
    chk("reset run", {7'h0, internal_hs_run}, 8'h1);
    nrst = 1'b1;
    foreach (rows[i]) begin
      {ext_input_select, hs_pin_mode_select, main_osc_stop} = rows[i][7:5];
      cyc(2);
      chk("pin modes", {3'h0, pins}, {3'h0, rows[i][4:0]});
    end
    chk("cpu status", stat, 8'h0);
    for (int k = 0; k < 6; k++) begin
      cpu_divider = k[2:0];
      cnt;
      chk("main int", m, 8'h40);
      chk("cpu ratio", c, 8'h40 >> (k > 4 ? 4 : k));
    end
    {ext_input_select, hs_pin_mode_select, main_osc_stop} = 3'h2;
    cyc(20);
    main_source_select = 1'b1;
    peripheral_source_select = 1'b1;
    cnt;
    chk("main hs", m, 8'h10);
    chk("periph hs", p, 8'h10);
    chk("status hs", stat, 8'h1);
    peripheral_source_select = 1'b0;
    cnt;
    chk("main split", m, 8'h40);
    chk("periph split", p, 8'h10);
    main_source_select = 1'b0;
    cnt;
    chk("periph int", p, 8'h40);
    cpu_source_select = 1'b1;
    cnt;
    chk("cpu sub", c, 8'h08);
    chk("status sub", stat, 8'h2);
    internal_hs_osc_stop = 1'b1;
    cyc(3);
    chk("osc halted", {7'h0, internal_hs_run}, 8'h0);
    internal_hs_osc_stop = 1'b0;
    for (n = 0; n < 50 && internal_hs_stable_flag !== 1'b1; n++) cyc(1);
    chk("settle", n[7:0], 8'h5);
    stop_mode = 1'b1;
    cyc(3);
    chk("stop mode", {7'h0, xtal_osc_enable}, 8'h0);
    chk("stop int", {7'h0, internal_hs_run}, 8'h0);
    nrst = 1'b0;
    stop_mode = 1'b0;
    cpu_source_select = 1'b0;
    cyc(2);
    chk("reset pins", {3'h0, pins}, 8'h0);
    chk("reset status", stat, 8'h0);
    chk("reset flag", {7'h0, internal_hs_stable_flag}, 8'h0);
    nrst = 1'b1;
    cnt;
    chk("cpu default", c, 8'h20);
    chk("main restart", m, 8'h40);
    chk("status int", stat, 8'h0);
    wrap_up;
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
